// ===== design/asr_host.sv
// Implementation choices: the register offsets and the APB slave port.
`default_nettype none
module asr_host #(
   parameter int SETTLE_CYC = asr_pkg::SETTLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   asr_link_if.host link
);
   import asr_pkg::*;
   // ----------------------------------------
   // state
   // ----------------------------------------
   asr_host_e state;
   logic run, auto_rd;
   logic [DATA_BITS-1:0] data_raw, offset;
   logic [STAT_BITS-1:0] stat;
   logic [15:0] gain_coef;
   logic [31:0] corr;
   logic [INT_BITS-1:0] int_stat, int_mask, ev;
   logic [SYNC_STAGES-1:0] dsync;
   logic dout_lvl;
   logic [WORD_BITS-1:0] shreg;
   logic [WORD_BITS-1:0] word;
   logic [4:0] bitcnt;
   logic [15:0] half;
   logic [31:0] settle;
   logic wr;
   logic signed [24:0] diff;
   logic signed [41:0] prod;

   function automatic logic mapped(input logic [7:0] a);
      mapped = a == REG_CTRL || a == REG_STATUS || a == REG_DATA
         || a == REG_STAT || a == REG_OFFSET || a == REG_GAIN
         || a == REG_CORR || a == REG_INT_STAT || a == REG_INT_MASK;
   endfunction

   assign wr = psel & penable & pready & pwrite;
   assign word = {shreg[WORD_BITS-2:0], dout_lvl};
   assign diff = $signed({1'b0, word[WORD_BITS-1:STAT_BITS]})
      - $signed({1'b0, offset});
   assign prod = diff * $signed({1'b0, gain_coef});
   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= !mapped(paddr);
         case (paddr)
            REG_CTRL: prdata <= {30'h0, auto_rd, run};
            REG_STATUS: prdata <= {29'h0, state == HST_WAIT,
               state == HST_LOW || state == HST_HIGH, run};
            REG_DATA: prdata <= {8'h0, data_raw};
            REG_STAT: prdata <= {24'h0, stat};
            REG_OFFSET: prdata <= {8'h0, offset};
            REG_GAIN: prdata <= {16'h0, gain_coef};
            REG_CORR: prdata <= corr;
            REG_INT_STAT: prdata <= {29'h0, int_stat};
            REG_INT_MASK: prdata <= {29'h0, int_mask};
            default: prdata <= 32'h0;
         endcase
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= 1'b0;
         auto_rd <= 1'b0;
         offset <= 24'h0;
         gain_coef <= GAIN_RESET;
         int_mask <= 3'h0;
      end else if (wr) begin
         case (paddr)
            REG_CTRL: begin
               run <= pwdata[CTRL_RUN];
               auto_rd <= pwdata[CTRL_AUTO];
            end
            REG_OFFSET: offset <= pwdata[DATA_BITS-1:0];
            REG_GAIN: gain_coef <= pwdata[15:0];
            REG_INT_MASK: int_mask <= pwdata[INT_BITS-1:0];
            default: ;
         endcase
      end
   end
   // ----------------------------------------
   // interrupts, set wins over clear
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat <= 3'h0;
         irq <= 1'b0;
      end else begin
         int_stat <= (int_stat & ~((wr && paddr == REG_INT_STAT)
            ? pwdata[INT_BITS-1:0] : 3'h0)) | ev;
         irq <= |(int_stat & int_mask);
      end
   end
   // ----------------------------------------
   // dout synchroniser
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dsync <= 3'h7;
         dout_lvl <= 1'b1;
      end else begin
         dsync <= {dsync[1:0], link.dout_line};
         if (dsync[1] == dsync[2]) begin
            dout_lvl <= dsync[2];
         end
      end
   end
   // ----------------------------------------
   // read sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= HST_OFF;
         link.sclk <= 1'b1;
         link.powerdown_reset_input_n <= 1'b0;
         shreg <= 32'h0;
         bitcnt <= 5'h0;
         half <= 16'h0;
         settle <= 32'h0;
         data_raw <= 24'h0;
         stat <= 8'h0;
         corr <= 32'h0;
         ev <= 3'h0;
      end else begin
         ev <= 3'h0;
         link.powerdown_reset_input_n <= run;
         if (!run) begin
            state <= HST_OFF;
            link.sclk <= 1'b1;
         end else begin
            case (state)
               HST_OFF: begin
                  settle <= 32'h0;
                  state <= HST_SETTLE;
               end
               HST_SETTLE: begin
                  settle <= settle + 32'h1;
                  if (settle == SETTLE_CYC - 1) begin
                     state <= HST_WAIT;
                  end
               end
               HST_WAIT: begin
                  if (auto_rd && !dout_lvl) begin
                     link.sclk <= 1'b0;
                     half <= 16'h0;
                     bitcnt <= 5'h0;
                     state <= HST_LOW;
                  end
               end
               HST_LOW: begin
                  half <= half + 16'h1;
                  if (half == SCLK_HALF_CYC - 1) begin
                     link.sclk <= 1'b1;
                     half <= 16'h0;
                     shreg <= word;
                     state <= HST_HIGH;
                     if (bitcnt == LAST_BIT) begin
                        state <= HST_GAP;
                        if (word[ST_PAT_HI:ST_PAT_LO] == PATTERN_OK) begin
                           data_raw <= word[WORD_BITS-1:STAT_BITS];
                           stat <= word[STAT_BITS-1:0];
                           corr <= {{6{prod[41]}}, prod[40:GAIN_FRAC]};
                           ev[INT_OK] <= 1'b1;
                           ev[INT_ERR] <= word[ST_ERR];
                        end else begin
                           ev[INT_BAD] <= 1'b1;
                        end
                     end
                  end
               end
               HST_HIGH: begin
                  half <= half + 16'h1;
                  if (half == SCLK_HALF_CYC - 1) begin
                     link.sclk <= 1'b0;
                     half <= 16'h0;
                     bitcnt <= bitcnt + 5'h1;
                     state <= HST_LOW;
                  end
               end
               HST_GAP: begin
                  if (dout_lvl) begin
                     state <= HST_WAIT;
                  end
               end
               default: state <= HST_OFF;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== inc/asr_pkg.sv
`default_nettype none
package asr_pkg;
   // ----------------------------------------
   // word layout
   // ----------------------------------------
   localparam int WORD_BITS = 32;
   localparam int DATA_BITS = 24;
   localparam int STAT_BITS = 8;
   localparam int ST_RDY = 7;
   localparam int ST_FILTER = 6;
   localparam int ST_ERR = 5;
   localparam int ST_ID_HI = 4;
   localparam int ST_ID_LO = 3;
   localparam int ST_GAIN = 2;
   localparam int ST_PAT_HI = 1;
   localparam int ST_PAT_LO = 0;
   localparam logic [1:0] PATTERN_OK = 2'h1;
   // arbitrary value
   localparam logic [1:0] PART_ID_DEFAULT = 2'h2;
   localparam logic [4:0] LAST_BIT = 5'h1f;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int SCLK_HALF_NS = 640;
   localparam int SCLK_HALF_CYC = SCLK_HALF_NS * CLK_MHZ / 1000;
   localparam int SETTLE_US = 1000;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   localparam int SYNC_STAGES = 3;
   // ----------------------------------------
   // host registers
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_OFFSET = 8'h10;
   localparam logic [7:0] REG_GAIN = 8'h14;
   localparam logic [7:0] REG_CORR = 8'h18;
   localparam logic [7:0] REG_INT_STAT = 8'h1c;
   localparam logic [7:0] REG_INT_MASK = 8'h20;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_AUTO = 1;
   localparam int INT_BITS = 3;
   localparam int INT_OK = 0;
   localparam int INT_BAD = 1;
   localparam int INT_ERR = 2;
   localparam int GAIN_FRAC = 15;
   localparam logic [15:0] GAIN_RESET = 16'h8000;
   typedef enum {DEV_OFF, DEV_IDLE, DEV_READY, DEV_SHIFT} asr_dev_e;
   typedef enum {HST_OFF, HST_SETTLE, HST_WAIT, HST_LOW, HST_HIGH,
      HST_GAP} asr_host_e;
endpackage
`default_nettype wire

// ===== inc/asr_link_if.sv
`default_nettype none
interface asr_link_if;
   logic sclk;
   logic powerdown_reset_input_n;
   logic dout_rdy;
   logic dout_oe;
   logic dout_line;
   // ----------------------------------------
   // line resolution, pulled high when idle
   // ----------------------------------------
   assign dout_line = dout_oe ? dout_rdy : 1'b1;
   modport dev (input sclk, input powerdown_reset_input_n, output dout_rdy,
      output dout_oe);
   modport host (output sclk, output powerdown_reset_input_n, input dout_line);
endinterface
`default_nettype wire

// ===== design/asr_dev.sv
// How it works
// - each read shifts 24 data plus 8 status
// - line goes low when word loaded
// - ready bit reads zero in available word
// - filter bit one for 10 Hz
// - error bit marks out-of-range conversion
// - fixed two-bit part identity in word
// - pattern bits always zero then one
// - host discards word on bad pattern
// - host may check pattern every read
// - switch open while power-down input low
// - switch stays open in power-down
// - switch closed in normal operation
// - host waits for settling before reading
// - host corrects with offset and gain
`default_nettype none
module asr_dev #(
   parameter logic [1:0] PART_ID = asr_pkg::PART_ID_DEFAULT
) (
   input wire logic pclk,
   input wire logic presetn,
   asr_link_if.dev link,
   input wire logic [asr_pkg::DATA_BITS-1:0] conv_data,
   input wire logic conv_valid,
   input wire logic conv_out_of_range,
   input wire logic filter_10hz,
   input wire logic gain_one,
   output logic bridge_supply_switch,
   output logic powered,
   output logic word_read
);
   import asr_pkg::*;
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   asr_dev_e state;
   logic [SYNC_STAGES-1:0] sclk_s;
   logic [SYNC_STAGES-1:0] pd_s;
   logic sclk_lvl;
   logic sclk_prev;
   logic pd_lvl;
   logic sclk_fall;
   logic sclk_rise;
   logic [SYNC_STAGES-1:0] filt_s;
   logic [SYNC_STAGES-1:0] gain_s;
   logic filt_lvl;
   logic gain_lvl;
   logic filt_q;
   logic gain_q;
   logic cfg_change;
   logic [WORD_BITS-1:0] shreg;
   logic [4:0] bitcnt;

   // ----------------------------------------
   // status byte
   // ----------------------------------------
   function automatic logic [STAT_BITS-1:0] status_byte(
      input logic filt, input logic err, input logic gain);
      logic [STAT_BITS-1:0] s;
      s = 8'h0;
      s[ST_RDY] = 1'b0;
      s[ST_FILTER] = filt;
      s[ST_ERR] = err;
      s[ST_ID_HI] = PART_ID[1];
      s[ST_ID_LO] = PART_ID[0];
      s[ST_GAIN] = gain;
      s[ST_PAT_HI] = PATTERN_OK[1];
      s[ST_PAT_LO] = PATTERN_OK[0];
      status_byte = s;
   endfunction

   // ----------------------------------------
   // link input synchronisers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_s <= 3'h7;
         pd_s <= 3'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], link.sclk};
         pd_s <= {pd_s[1:0], link.powerdown_reset_input_n};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_lvl <= 1'b1;
         sclk_prev <= 1'b1;
         pd_lvl <= 1'b0;
      end else begin
         if (sclk_s[1] == sclk_s[2]) begin
            sclk_lvl <= sclk_s[2];
         end
         if (pd_s[1] == pd_s[2]) begin
            pd_lvl <= pd_s[2];
         end
         sclk_prev <= sclk_lvl;
      end
   end

   assign sclk_fall = sclk_prev & ~sclk_lvl;
   assign sclk_rise = ~sclk_prev & sclk_lvl;

   // ----------------------------------------
   // pin setting watch
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_s <= 3'h0;
         gain_s <= 3'h0;
         filt_lvl <= 1'b0;
         gain_lvl <= 1'b0;
         filt_q <= 1'b0;
         gain_q <= 1'b0;
      end else begin
         filt_s <= {filt_s[1:0], filter_10hz};
         gain_s <= {gain_s[1:0], gain_one};
         if (filt_s[1] == filt_s[2]) begin
            filt_lvl <= filt_s[2];
         end
         if (gain_s[1] == gain_s[2]) begin
            gain_lvl <= gain_s[2];
         end
         filt_q <= filt_lvl;
         gain_q <= gain_lvl;
      end
   end

   assign cfg_change = (filt_q != filt_lvl) | (gain_q != gain_lvl);

   // ----------------------------------------
   // bridge switch and power state
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_supply_switch <= 1'b0;
         powered <= 1'b0;
      end else if (!pd_lvl) begin
         bridge_supply_switch <= 1'b0;
         powered <= 1'b0;
      end else begin
         bridge_supply_switch <= 1'b1;
         powered <= 1'b1;
      end
   end

   // ----------------------------------------
   // output word sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= DEV_OFF;
         link.dout_rdy <= 1'b1;
         link.dout_oe <= 1'b0;
         shreg <= 32'h0;
         bitcnt <= 5'h0;
         word_read <= 1'b0;
      end else begin
         word_read <= 1'b0;
         if (!pd_lvl) begin
            state <= DEV_OFF;
            link.dout_rdy <= 1'b1;
            link.dout_oe <= 1'b0;
            bitcnt <= 5'h0;
         end else if (state == DEV_OFF) begin
            state <= DEV_IDLE;
            link.dout_rdy <= 1'b1;
            link.dout_oe <= 1'b1;
         end else if (cfg_change) begin
            state <= DEV_IDLE;
            link.dout_rdy <= 1'b1;
            bitcnt <= 5'h0;
         end else if (conv_valid) begin
            shreg <= {conv_data,
               status_byte(filt_lvl, conv_out_of_range, gain_lvl)};
            bitcnt <= 5'h0;
            state <= DEV_READY;
            link.dout_rdy <= 1'b0;
         end else begin
            case (state)
               DEV_IDLE: begin
                  link.dout_rdy <= 1'b1;
               end
               DEV_READY: begin
                  if (sclk_fall) begin
                     link.dout_rdy <= shreg[WORD_BITS-1];
                     shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                     state <= DEV_SHIFT;
                  end
               end
               DEV_SHIFT: begin
                  if (sclk_fall) begin
                     link.dout_rdy <= shreg[WORD_BITS-1];
                     shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                  end else if (sclk_rise) begin
                     bitcnt <= bitcnt + 5'h1;
                     if (bitcnt == LAST_BIT) begin
                        state <= DEV_IDLE;
                        link.dout_rdy <= 1'b1;
                        word_read <= 1'b1;
                     end
                  end
               end
               default: state <= DEV_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/asr_link_sva.sv
`default_nettype none
module asr_link_chk #(
   parameter logic [1:0] PART_ID = 2'h2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sclk,
   input wire logic powerdown_reset_input_n,
   input wire logic dout_rdy,
   input wire logic dout_oe,
   input wire logic dout_line,
   input wire logic conv_valid,
   input wire logic bridge_supply_switch
);
   import asr_pkg::*;
   logic sclk_q;
   logic rise;
   logic [5:0] rises;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // serial clock rise counter
   // ----------------------------------------
   assign rise = sclk && !sclk_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b1;
      end else begin
         sclk_q <= sclk;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rises <= 6'h00;
      end else if (!dout_oe || rises == 6'h20) begin
         rises <= 6'h00;
      end else if (rise) begin
         rises <= rises + 6'h01;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_SW_OPEN: assert property (
      !powerdown_reset_input_n [*6] |-> !bridge_supply_switch)
      else $error("switch closed during power-down");
   AST_PD_TRISTATE: assert property (
      !powerdown_reset_input_n [*6] |-> !dout_oe && dout_line)
      else $error("data line driven during power-down");
   AST_SW_CLOSED: assert property (
      powerdown_reset_input_n [*6] |-> bridge_supply_switch)
      else $error("switch open in normal operation");
   AST_SW_WITH_LINE: assert property (
      $rose(bridge_supply_switch) |-> dout_oe && dout_line)
      else $error("line not active high when switch closes");
   AST_LOAD_LOW: assert property (
      conv_valid && dout_oe |=> !dout_rdy)
      else $error("line not low after word load");
   AST_END_HIGH: assert property (
      rises == 6'h20 |-> ##[0:8] dout_rdy)
      else $error("line not high after 32 bits");
   AST_RDY_BIT: assert property (
      rise && rises == 6'h18 |-> !dout_line)
      else $error("ready bit not zero");
   AST_ID_HI: assert property (
      rise && rises == 6'h1b |-> dout_line == PART_ID[1])
      else $error("identity upper bit wrong");
   AST_ID_LO: assert property (
      rise && rises == 6'h1c |-> dout_line == PART_ID[0])
      else $error("identity lower bit wrong");
   AST_PAT_HI: assert property (
      rise && rises == 6'h1e |-> !dout_line)
      else $error("upper pattern bit not zero");
   AST_PAT_LO: assert property (
      rise && rises == 6'h1f |-> dout_line)
      else $error("lower pattern bit not one");
endmodule
`default_nettype wire

// ===== verification/adc_status_byte_readout_tb.sv
`default_nettype none
module adc_status_byte_readout_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import asr_pkg::*;
   // arbitrary value
   localparam logic [1:0] PART_ID = 2'h2;
   localparam int LIMIT = 40000;
   logic pclk;
   logic presetn;
   logic [1:0] psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prd [2];
   logic rdy [2];
   logic serr [2];
   logic irq [2];
   logic [23:0] conv_data;
   logic conv_valid;
   logic oor;
   logic filt;
   logic gain;
   logic e;
   logic lerr;
   logic sw;
   logic pwr;
   logic [31:0] q;
   logic [31:0] bad;
   logic wrd;
   int reads = 0;
   int err_count;
   int checks_done;
   int cycles;
   asr_link_if l1 ();
   asr_link_if l2 ();
   asr_dev #(.PART_ID(PART_ID)) i_asr_dev (.pclk(pclk), .presetn(presetn),
      .link(l1.dev), .conv_data(conv_data), .conv_valid(conv_valid),
      .conv_out_of_range(oor), .filter_10hz(filt), .gain_one(gain),
      .bridge_supply_switch(sw), .powered(pwr), .word_read(wrd));
   asr_host #(.SETTLE_CYC(20)) i_asr_host (.pclk(pclk), .presetn(presetn),
      .psel(psel[0]), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prd[0]), .pready(rdy[0]),
      .pslverr(serr[0]), .irq(irq[0]), .link(l1.host));
   asr_host #(.SETTLE_CYC(20)) i_asr_host_2 (.pclk(pclk), .presetn(presetn),
      .psel(psel[1]), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prd[1]), .pready(rdy[1]),
      .pslverr(serr[1]), .irq(irq[1]), .link(l2.host));
   asr_link_chk #(.PART_ID(PART_ID)) i_asr_link_chk (.pclk(pclk),
      .presetn(presetn), .sclk(l1.sclk), .powerdown_reset_input_n(l1.powerdown_reset_input_n),
      .dout_rdy(l1.dout_rdy), .dout_oe(l1.dout_oe),
      .dout_line(l1.dout_line), .conv_valid(conv_valid),
      .bridge_supply_switch(sw));
   // ----------------------------------------
   // clock and timeout
   // ----------------------------------------
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_count++;
         final_report();
      end
   end
   always @(posedge pclk) begin
      if (wrd === 1'b1) begin
         reads++;
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input int s, input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= (s == 0) ? 2'h1 : 2'h2;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (rdy[s] !== 1'b1) begin
         @(posedge pclk);
      end
      q = prd[s];
      lerr = serr[s];
      psel <= 2'h0;
      penable <= 1'b0;
   endtask
   task automatic rd(input int s, input logic [7:0] a, input logic [31:0] x);
      apb(s, 1'b0, a, 32'h0);
      check(q, x);
   endtask
   task automatic wait_irq(input int s);
      int n;
      n = 0;
      while (irq[s] !== 1'b1 && n < 5000) begin
         n++;
         @(posedge pclk);
      end
      check(32'(irq[s]), 32'h1);
   endtask
   task automatic convert(input logic [23:0] d);
      @(posedge pclk);
      conv_data <= d;
      conv_valid <= 1'b1;
      @(posedge pclk);
      conv_valid <= 1'b0;
      wait_irq(0);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 2'h0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      conv_data = 24'h0;
      conv_valid = 1'b0;
      oor = 1'b0;
      filt = 1'b0;
      gain = 1'b0;
      l2.dout_oe = 1'b0;
      l2.dout_rdy = 1'b1;
      err_count = 0;
      checks_done = 0;
      cycles = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(0, REG_INT_MASK, 32'h0);
      rd(0, REG_GAIN, 32'h8000);
      rd(0, REG_OFFSET, 32'h0);
      rd(0, 8'h40, 32'h0);
      check(32'(lerr), 32'h1);
      $display("test 1 done");
      apb(0, 1'b1, REG_INT_MASK, 32'h7);
      apb(0, 1'b1, REG_CTRL, 32'h3);
      for (int i = 0; i < 4; i++) begin
         e = i[0] ^ i[1];
         @(posedge pclk);
         filt <= i[0];
         gain <= i[1];
         oor <= e;
         repeat (40) @(posedge pclk);
         convert(24'h012345 + 24'(i));
         rd(0, REG_DATA, 32'h012345 + 32'(i));
         rd(0, REG_STAT,
            {24'h0, 1'b0, i[0], e, PART_ID, i[1], 2'h1});
         rd(0, REG_CORR, 32'h012345 + 32'(i));
         rd(0, REG_INT_STAT, {29'h0, e, 2'h1});
         apb(0, 1'b1, REG_INT_STAT, 32'h7);
         repeat (2) @(posedge pclk);
         check(32'(irq[0]), 32'h0);
      end
      apb(0, 1'b1, REG_OFFSET, 32'h100);
      apb(0, 1'b1, REG_GAIN, 32'h4000);
      convert(24'h012345);
      rd(0, REG_CORR, 32'h9122);
      apb(0, 1'b1, REG_INT_STAT, 32'h7);
      convert(24'h000000);
      rd(0, REG_CORR, 32'hffffff80);
      $display("test 2 done");
      apb(0, 1'b1, REG_CTRL, 32'h0);
      repeat (8) @(posedge pclk);
      check(32'(sw), 32'h0);
      check(32'(pwr), 32'h0);
      check(32'(l1.dout_line), 32'h1);
      check(32'(reads), 32'h6);
      apb(0, 1'b1, REG_CTRL, 32'h3);
      repeat (8) @(posedge pclk);
      check(32'(sw), 32'h1);
      $display("test 3 done");
      apb(1, 1'b1, REG_INT_MASK, 32'h7);
      apb(1, 1'b1, REG_CTRL, 32'h3);
      repeat (40) @(posedge pclk);
      for (int p = 0; p < 3; p++) begin
         bad = {24'habcdef, 6'h0, 2'(p == 0 ? 0 : p + 1)};
         @(posedge pclk);
         l2.dout_oe <= 1'b1;
         l2.dout_rdy <= 1'b0;
         for (int b = 31; b >= 0; b--) begin
            @(negedge l2.sclk);
            @(posedge pclk);
            l2.dout_rdy <= bad[b];
         end
         @(posedge l2.sclk);
         @(posedge pclk);
         l2.dout_rdy <= 1'b1;
         wait_irq(1);
         rd(1, REG_INT_STAT, 32'h2);
         rd(1, REG_DATA, 32'h0);
         check(32'(lerr), 32'h0);
         apb(1, 1'b1, REG_INT_STAT, 32'h7);
      end
      $display("test 4 done");
      final_report();
   end
endmodule
`default_nettype wire
